// ### src/hbibs_pkg.sv
// Purpose: shared constants for the host bus port with bank select
// Assumes: 20 MHz system clock, 8-bit host data, 4 host address lines
// Notes: register indices are unified internal selects, not host addresses
package hbibs_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	// internal register select: {bank, index[3:0]} gives 32 slots
	localparam int SEL_W = 5;
	// operating-mode register: demux address and muxed address
	localparam logic [3:0] OPMODE_DMX_ADDR = 4'ha;
	localparam logic [3:0] OPMODE_MUX_ADDR = 4'h4;
	localparam logic [4:0] OPMODE_SEL = 5'h0a;
	localparam int BANK_BIT_POS = 0;
	localparam logic [7:0] OPMODE_RESET = 8'h00;
	// select range taken by the muxed map: banks folded by address
	localparam logic [4:0] MUX_INIT_BASE = 5'h10;
	// bus styles
	typedef enum logic [1:0] {
		HBIBS_STYLE_STROBE_DIR = 2'b00,
		HBIBS_STYLE_SEP_STROBE = 2'b01,
		HBIBS_STYLE_MUXED = 2'b10
	} hbibs_style_t;
	// access directions per register
	localparam logic [1:0] ACC_RO = 2'b01;
	localparam logic [1:0] ACC_WO = 2'b10;
	localparam logic [1:0] ACC_RW = 2'b11;
endpackage

// ### src/hbibs_port.sv
// Purpose: 8-bit parallel host port with style detection and bank select
// Assumes: host pins asynchronous to clk, sampled by two flip-flops
// Notes: strobes are edge detected after sync, so a strobe must last >3 clk
//
// Function
// - register and fifo data move over an 8-bit two-way data bus
// - four address lines select the register being accessed
// - latch pin high, low or toggling picks the bus style
// - two pins are read/write strobes or data strobe plus direction
// - muxed mode uses even addresses; address bit zero forced low
// - muxed and demuxed modes use different address maps
// - demuxed select is bank bit joined with four address lines
// - bank bit one reaches the initialization bank
// - bank bit zero reaches the operational bank
// - operating-mode register sits at one address in both banks
// - each register allows only its supported access directions
// - every register and fifo except slot 26 (bank one, address a) is reachable through this port
// - any latch edge locks muxed mode until hardware reset
`timescale 1ns/1ns
module hbibs_port #(
	parameter int NREG = 32
) (
	// clock and hardware reset
	input wire logic clk,
	input wire logic rst,
	// host bus pins
	input wire logic chip_sel_n,
	input wire logic addr_latch,
	input wire logic [3:0] addr_in,
	input wire logic pin_rd_n,
	input wire logic pin_wr_n,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// fifo side
	output logic fifo_push,
	output logic fifo_pop,
	input wire logic [7:0] fifo_rdata,
	// status
	output logic [1:0] bus_style,
	output logic register_bank_select_bit
);
	// synchronised pins; stage zero is read only by stage one
	logic [1:0] ale_s_r;
	logic [1:0] cs_s_r;
	logic [1:0] rd_s_r;
	logic [1:0] wr_s_r;
	logic [3:0] a0_s_r;
	logic [3:0] a1_s_r;
	logic [7:0] d0_s_r;
	logic [7:0] d1_s_r;
	// latch pin history, strap and mode lock
	logic ale_d_r;
	logic ale_edge;
	logic strap_r;
	logic strap_taken_r;
	logic muxed_r;
	// address decode and access strobes
	logic [3:0] mux_addr_r;
	logic [4:0] sel;
	logic [3:0] eff_addr;
	logic rd_act;
	logic wr_act;
	logic rd_act_d_r;
	logic wr_act_d_r;
	logic rd_stb;
	logic wr_stb;
	logic [7:0] rdata;
	hbibs_pkg::hbibs_style_t style;

	// latch sync runs through reset too, so the strap has settled
	// by release; a reset value here would fake an edge afterwards
	always_ff @(posedge clk) begin
		ale_s_r <= {ale_s_r[0], addr_latch};
	end

	// strobe syncs park at the idle level: no access during reset
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_s_r <= 2'b11;
			rd_s_r <= 2'b11;
			wr_s_r <= 2'b11;
		end else begin
			cs_s_r <= {cs_s_r[0], chip_sel_n};
			rd_s_r <= {rd_s_r[0], pin_rd_n};
			wr_s_r <= {wr_s_r[0], pin_wr_n};
		end
	end

	// address and data take the same two stages as the strobes,
	// so they line up with the strobe that qualifies them
	always_ff @(posedge clk) begin
		if (rst) begin
			a0_s_r <= 4'h0;
			a1_s_r <= 4'h0;
			d0_s_r <= 8'h00;
			d1_s_r <= 8'h00;
		end else begin
			a0_s_r <= addr_in;
			a1_s_r <= a0_s_r;
			d0_s_r <= data_in;
			d1_s_r <= d0_s_r;
		end
	end

	// latch history follows the pin through reset as well
	always_ff @(posedge clk) begin
		ale_d_r <= ale_s_r[1];
	end
	assign ale_edge = ale_s_r[1] != ale_d_r;

	// strap caught at first clock after reset release
	always_ff @(posedge clk) begin
		if (rst) begin
			strap_taken_r <= 1'b0;
		end else begin
			strap_taken_r <= 1'b1;
		end
	end

	// strap value frozen once taken; later latch levels do not count
	always_ff @(posedge clk) begin
		if (rst) begin
			strap_r <= 1'b0;
		end else if (!strap_taken_r) begin
			strap_r <= ale_s_r[1];
		end
	end

	// any latch edge locks muxed mode; only reset clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			muxed_r <= 1'b0;
		end else if (strap_taken_r && ale_edge) begin
			muxed_r <= 1'b1;
		end
	end

	// muxed address taken from data lines at latch falling edge
	always_ff @(posedge clk) begin
		if (rst) begin
			mux_addr_r <= 4'h0;
		end else if (ale_d_r && !ale_s_r[1]) begin
			mux_addr_r <= {d1_s_r[3:1], 1'b0};
		end
	end

	always_comb begin
		if (muxed_r) begin
			style = hbibs_pkg::HBIBS_STYLE_MUXED;
		end else if (strap_r) begin
			style = hbibs_pkg::HBIBS_STYLE_STROBE_DIR;
		end else begin
			style = hbibs_pkg::HBIBS_STYLE_SEP_STROBE;
		end
	end
	assign bus_style = style;

	// pin meaning depends on style: in strobe-dir style rd pin is data strobe, wr pin direction
	always_comb begin
		if (style == hbibs_pkg::HBIBS_STYLE_STROBE_DIR) begin
			rd_act = !cs_s_r[1] && !rd_s_r[1] && wr_s_r[1];
			wr_act = !cs_s_r[1] && !rd_s_r[1] && !wr_s_r[1];
		end else begin
			rd_act = !cs_s_r[1] && !rd_s_r[1];
			wr_act = !cs_s_r[1] && !wr_s_r[1];
		end
	end

	// one access per strobe: act on the leading edge only
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_act_d_r <= 1'b0;
			wr_act_d_r <= 1'b0;
		end else begin
			rd_act_d_r <= rd_act;
			wr_act_d_r <= wr_act;
		end
	end
	assign rd_stb = rd_act && !rd_act_d_r;
	// write data taken at trailing edge-free point: leading edge plus sync
	assign wr_stb = wr_act && !wr_act_d_r;

	// map: muxed map uses address bits 3..1, bank from bit 3
	always_comb begin
		eff_addr = muxed_r ? mux_addr_r : a1_s_r;
		if (muxed_r) begin
			if (eff_addr == hbibs_pkg::OPMODE_MUX_ADDR) begin
				sel = hbibs_pkg::OPMODE_SEL;
			end else begin
				sel = {eff_addr[3], 1'b0, eff_addr[2:0]};
			end
		end else if (eff_addr == hbibs_pkg::OPMODE_DMX_ADDR) begin
			sel = hbibs_pkg::OPMODE_SEL;
		end else begin
			// bank one is init bank, bank zero operational
			sel = {register_bank_select_bit, eff_addr};
		end
	end

	hbibs_regfile #(
		.NREG(NREG)
	) u_regs (
		.clk(clk),
		.rst(rst),
		.sel(sel),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.wdata(d1_s_r),
		.rdata(rdata),
		.fifo_push(fifo_push),
		.fifo_pop(fifo_pop),
		.fifo_rdata(fifo_rdata),
		.bank_sel(register_bank_select_bit)
	);

	// drive the bus while the host holds a read
	always_ff @(posedge clk) begin
		if (rst) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= rd_act;
		end
	end
	assign data_out = rdata;
endmodule

// ### src/hbibs_regfile.sv
// Purpose: register and fifo window behind the host bus port
// Assumes: one-cycle write strobe and read strobe from the port logic
// Notes: access rights come from a constant table; illegal direction ignored
`timescale 1ns/1ns
module hbibs_regfile #(
	parameter int NREG = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// access from port logic
	input wire logic [4:0] sel,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// fifo side
	output logic fifo_push,
	output logic fifo_pop,
	input wire logic [7:0] fifo_rdata,
	// operating-mode bank select bit
	output logic bank_sel
);
	logic [7:0] mem_r [NREG];
	logic [1:0] acc;
	logic is_fifo;

	// access rights: slot 1 and 17 are read only status, 2 is write only
	always_comb begin
		case (sel)
		5'h01, 5'h11: acc = hbibs_pkg::ACC_RO;
		5'h02: acc = hbibs_pkg::ACC_WO;
		default: acc = hbibs_pkg::ACC_RW;
		endcase
	end

	// slot 0 of each bank is the fifo data port
	assign is_fifo = (sel[3:0] == 4'h0);
	assign fifo_push = wr_stb && is_fifo && acc[1];
	assign fifo_pop = rd_stb && is_fifo && acc[0];

	// storage, writes dropped where the slot is read only
	generate
		for (genvar i = 0; i < NREG; i++) begin : g_reg
			always_ff @(posedge clk) begin
				if (rst) begin
					mem_r[i] <= (i == int'(hbibs_pkg::OPMODE_SEL)) ?
						hbibs_pkg::OPMODE_RESET : 8'h00;
				end else if (wr_stb && acc[1] && sel == 5'(i)) begin
					mem_r[i] <= wdata;
				end
			end
		end
	endgenerate

	// read data registered; write-only slots read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd_stb) begin
			if (!acc[0]) begin
				rdata <= 8'h00;
			end else if (is_fifo) begin
				rdata <= fifo_rdata;
			end else begin
				rdata <= mem_r[sel];
			end
		end
	end

	assign bank_sel = mem_r[hbibs_pkg::OPMODE_SEL][hbibs_pkg::BANK_BIT_POS];
endmodule

// ### test/hbibs_chk.sv
// Purpose: pin timing checks on the host port
// Assumes: one clock, sync active-high reset
// Notes: strobes reach logic after a two-stage sync
`timescale 1ns/1ns
module hbibs_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host strobes
	input wire logic chip_sel_n,
	input wire logic pin_rd_n,
	input wire logic pin_wr_n,
	// outputs watched
	input wire logic data_oe,
	input wire logic fifo_push,
	input wire logic fifo_pop,
	input wire logic [1:0] bus_style,
	input wire logic register_bank_select_bit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// bus drive only after a selected read strobe
	chk_oe_after_rd: assert property ($rose(data_oe) |->
		!$past(pin_rd_n, 2) && !$past(chip_sel_n, 2)
		&& $past(pin_wr_n, 2))
		else $error("bus driven without read");
	chk_oe_release: assert property ($rose(pin_rd_n) |-> ##[1:4] !data_oe)
		else $error("bus held after strobe");
	chk_style_legal: assert property (bus_style != 2'b11)
		else $error("illegal bus style");
	chk_mux_sticky: assert property (
		bus_style == hbibs_pkg::HBIBS_STYLE_MUXED
		|=> bus_style == hbibs_pkg::HBIBS_STYLE_MUXED)
		else $error("muxed lost");
	chk_pop_pulse: assert property (fifo_pop |=> !fifo_pop)
		else $error("pop too long");
	chk_push_pulse: assert property (fifo_push |=> !fifo_push)
		else $error("push too long");
	chk_push_on_wr: assert property (fifo_push |-> !$past(pin_wr_n, 2))
		else $error("push without write");
	chk_pop_on_rd: assert property (fifo_pop |-> !$past(pin_rd_n, 2))
		else $error("pop without read");
	chk_bank_by_wr: assert property ($changed(register_bank_select_bit)
		|-> !$past(pin_wr_n, 3)) else $error("bank moved without write");
endmodule
bind hbibs_port hbibs_chk u_chk (.clk(clk), .rst(rst),
	.chip_sel_n(chip_sel_n), .pin_rd_n(pin_rd_n), .pin_wr_n(pin_wr_n),
	.data_oe(data_oe), .fifo_push(fifo_push), .fifo_pop(fifo_pop),
	.bus_style(bus_style),
	.register_bank_select_bit(register_bank_select_bit));

// ### test/hbibs_host.sv
// Purpose: host processor model on the parallel bus
// Assumes: pins change at falling clock edge
// Notes: strobes held 6 clk, far above the 4 clk minimum
`timescale 1ns/1ns
module hbibs_host (
	// clock
	input wire logic clk,
	// host pins
	output logic chip_sel_n,
	output logic addr_latch,
	output logic [3:0] addr_in,
	output logic pin_rd_n,
	output logic pin_wr_n,
	output logic [7:0] hd,
	// device read data
	input wire logic [7:0] data_out
);
	logic [1:0] md;
	// idle pins at time zero
	initial begin
		{chip_sel_n, pin_rd_n, pin_wr_n, addr_latch, md} = 6'h38;
		addr_in = 4'h0;
		hd = 8'h00;
	end
	task set(input logic [1:0] m, input logic s);
		md = m;
		addr_latch = s;
	endtask
	// one access; outside muxed mode released data shows inverted and a read inverts it back to the last byte driven
	task acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		chip_sel_n = 1'b0;
		addr_in = a;
		if (md == 2'b10) begin
			hd = {4'h0, a};
			addr_latch = 1'b1;
			repeat (4) @(negedge clk);
			addr_latch = 1'b0;
			repeat (4) @(negedge clk);
		end
		hd = w ? d : ~hd;
		if (md == 2'b00) begin
			pin_wr_n = !w;
			@(negedge clk);
			pin_rd_n = 1'b0;
		end else if (w)
			pin_wr_n = 1'b0;
		else
			pin_rd_n = 1'b0;
		repeat (6) @(negedge clk);
		q = data_out;
		{pin_rd_n, pin_wr_n, chip_sel_n} = 3'h7;
		hd = ~hd;
		repeat (6) @(negedge clk);
	endtask
endmodule

// ### test/tb_top.sv
// Purpose: self-checking bench for the host port
// Assumes: 20 MHz clock, inputs change at falling edge
// Notes: expected values come from the style and bank map
`timescale 1ns/1ns
`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
	err_count++; end end
module tb_top;
	logic clk = 1'b0, rst = 1'b1, data_oe, fifo_push, fifo_pop, bnk;
	logic chip_sel_n, addr_latch, pin_rd_n, pin_wr_n;
	logic [3:0] addr_in;
	logic [7:0] data_in, data_out, hd, q, fifo_rdata = 8'h5c;
	logic [1:0] bus_style;
	int err_count = 0, samples_checked = 0;
	int push_cnt = 0, pop_cnt = 0;
	// clock and shared data wire
	always #25 clk = ~clk;
	assign data_in = data_oe ? data_out : hd;
	// fifo strobes counted mid-cycle, where a one-cycle pulse stands
	always @(negedge clk) begin
		if (fifo_push === 1'b1)
			push_cnt++;
		if (fifo_pop === 1'b1)
			pop_cnt++;
	end
	// host reads the shared wire, so a dropped bus drive shows up
	hbibs_host u_host (.clk(clk), .chip_sel_n(chip_sel_n),
		.addr_latch(addr_latch), .addr_in(addr_in), .pin_rd_n(pin_rd_n),
		.pin_wr_n(pin_wr_n), .hd(hd), .data_out(data_in));
	hbibs_port u_dut (.clk(clk), .rst(rst), .chip_sel_n(chip_sel_n),
		.addr_latch(addr_latch), .addr_in(addr_in), .pin_rd_n(pin_rd_n),
		.pin_wr_n(pin_wr_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .fifo_push(fifo_push), .fifo_pop(fifo_pop),
		.fifo_rdata(fifo_rdata), .bus_style(bus_style),
		.register_bank_select_bit(bnk));
	task results;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task do_rst(input logic [1:0] m, input logic s);
		@(negedge clk);
		rst = 1'b1;
		u_host.set(m, s);
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		`CK(bus_style, (m == 2'b10) ? 2'b01 : m)
	endtask
	task w(input logic [3:0] a, input logic [7:0] d);
		u_host.acc(1'b1, a, d, q);
	endtask
	task r(input logic [3:0] a, input logic [7:0] e);
		u_host.acc(1'b0, a, 8'h00, q);
		`CK(q, e)
	endtask
	// separate strobes, both banks
	task t_demux;
		do_rst(2'b01, 1'b0);
		w(4'h3, 8'ha5);
		r(4'h3, 8'ha5);
		r(4'h2, 8'h00);
		r(4'h0, 8'h5c);
		`CK(pop_cnt, 1)
		w(4'h0, 8'h11);
		`CK(push_cnt, 1)
		w(4'h1, 8'hff);
		r(4'h1, 8'h00);
		w(4'h4, 8'h01);
		`CK(bnk, 1'b0)
		w(4'ha, 8'h01);
		`CK(bnk, 1'b1)
		w(4'h3, 8'h3c);
		r(4'h3, 8'h3c);
		r(4'ha, 8'h01);
		w(4'ha, 8'h00);
		r(4'h3, 8'ha5);
	endtask
	// strobe plus direction, then muxed lock and reset
	task t_styles;
		do_rst(2'b00, 1'b1);
		w(4'h5, 8'h96);
		r(4'h5, 8'h96);
		do_rst(2'b10, 1'b0);
		w(4'h4, 8'h01);
		`CK(bnk, 1'b1)
		`CK(bus_style, 2'b10)
		w(4'h6, 8'h77);
		r(4'h7, 8'h77);
		do_rst(2'b01, 1'b0);
	endtask
	initial begin
		t_demux();
		t_styles();
		results();
	end
	// hang guard, far beyond the run length
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		results();
	end
endmodule
